// [pccr_defines.vh]
`ifndef PCCR_DEFINES_VH
`define PCCR_DEFINES_VH
// Register offsets
`define PCCR_OFF_CMD_STAT 8'h04
`define PCCR_OFF_CLASS_REV 8'h08
// Command/status bit positions
`define PCCR_BIT_IO_SPACE 0
`define PCCR_BIT_MEM_SPACE 1
`define PCCR_BIT_BUS_MASTER 2
`define PCCR_BIT_PARITY_RESP 6
`define PCCR_BIT_SYS_ERR_RESP 8
`define PCCR_BIT_NEW_CAPS 20
`define PCCR_BIT_PARITY_SEEN 31
// Option register bit that mirrors into new capabilities
`define PCCR_BIT_OPT_PM_CAP 19
// Host status system-error bit
`define PCCR_BIT_HOST_SYS_ERR 13
// Byte lanes that carry the writable fields
`define PCCR_LANE_CMD_LO 0
`define PCCR_LANE_CMD_HI 1
`define PCCR_LANE_STAT_HI 3
// Reset values
`define PCCR_RST_IO_SPACE 1'b1
`define PCCR_RST_MEM_SPACE 1'b1
`define PCCR_RST_BUS_MASTER 1'b1
`define PCCR_RST_PARITY_RESP 1'b0
`define PCCR_RST_SYS_ERR_RESP 1'b1
// Class code fields
`define PCCR_BASE_CLASS 8'h02
`define PCCR_SUBCLASS 8'h00
`define PCCR_RESERVED_BYTE 8'h00
`endif

// [pccr_event_sync.v]
`timescale 1ns/1ps
`include "pccr_defines.vh"
// Three-stage synchroniser for an outside pulse; emits one-cycle pulse on rise
module pccr_event_sync (
  input wire mclk_in,
  input wire reset_in,
  input wire async_in,
  output wire pulse_out
);
  reg stage1_ff;
  reg stage2_ff;
  reg stage3_ff;
  reg seen_ff;
  always @(posedge mclk_in) begin
    if (reset_in) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
      stage3_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      if (stage2_ff == stage3_ff) begin
        seen_ff <= stage3_ff;
      end
    end
  end
  // Change counts once stages two and three agree
  assign pulse_out = (stage2_ff == stage3_ff) && stage3_ff && !seen_ff;
endmodule // pccr_event_sync

// [pccr_cfg_regs.v]
`timescale 1ns/1ps
`include "pccr_defines.vh"
// Functional notes
// - New-capabilities bit mirrors option bit 19
// - Sys-error enable set drives system error on address parity errors only
// - Bus mastering only while master enable set
// - Memory decoding only while memory enable set
// - I/O control: zero enables, one disables
// - Base class code 02h in bits 31:24
// - Subclass 00h bits 23:16, 15:8 reserved
// - Fixed revision and step numbers, four bits
// - Parity-seen flag sets on every parity error
module pccr_cfg_regs #(
  parameter [3:0] REVISION_NUMBER = 4'h0, // Arbitrary value
  parameter [3:0] STEP_NUMBER = 4'h0 // Arbitrary value
) (
  input wire mclk_in,
  input wire reset_in,
  input wire cfg_wr_in,
  input wire cfg_rd_in,
  input wire [7:0] cfg_addr_in,
  input wire [31:0] cfg_wdata_in,
  input wire [3:0] cfg_be_in,
  output reg [31:0] cfg_rdata_out,
  output reg cfg_rvalid_out,
  input wire [31:0] option_config_reg_in,
  input wire addr_parity_err_in,
  input wire data_parity_err_in,
  input wire master_req_in,
  input wire mem_access_in,
  input wire io_access_in,
  output wire master_start_out,
  output wire mem_decode_out,
  output wire io_decode_out,
  output reg sys_err_n_out,
  output reg sys_err_n_oe_out,
  output reg host_sys_err_set_out,
  output wire bus_master_enable_out,
  output wire mem_space_enable_out,
  output wire io_space_control_out,
  output wire parity_resp_enable_out,
  output wire sys_err_resp_enable_out
);
  // Parity error sources, one synchroniser each
  localparam PERR_SOURCES = 2;
  localparam PERR_ADDR = 0;
  localparam PERR_DATA = 1;
  reg io_space_control_ff;
  reg mem_space_enable_ff;
  reg bus_master_enable_ff;
  reg parity_resp_enable_ff;
  reg sys_err_resp_enable_ff;
  reg parity_error_seen_flag_ff;
  reg [31:0] cmd_stat_word;
  wire [PERR_SOURCES-1:0] perr_raw;
  wire [PERR_SOURCES-1:0] perr_pulse;
  wire addr_perr_pulse;
  wire data_perr_pulse;
  wire any_perr;
  wire wr_cmd;
  wire wr_lane_lo;
  wire wr_lane_hi;
  wire wr_lane_stat;
  wire rd_cmd;
  wire rd_cls;
  wire [31:0] class_rev_word;
  genvar gi;

  //////////////////////////////////////////////////////////////////////////////
  // Offset match shared by the write and read decoders
  function addr_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Parity error inputs come from pins
  assign perr_raw[PERR_ADDR] = addr_parity_err_in;
  assign perr_raw[PERR_DATA] = data_parity_err_in;
  generate
    for (gi = 0; gi < PERR_SOURCES; gi = gi + 1) begin : g_perr_sync
      pccr_event_sync u_sync (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(perr_raw[gi]),
        .pulse_out(perr_pulse[gi])
      );
    end
  endgenerate
  assign addr_perr_pulse = perr_pulse[PERR_ADDR];
  assign data_perr_pulse = perr_pulse[PERR_DATA];
  assign any_perr = addr_perr_pulse | data_perr_pulse;

  //////////////////////////////////////////////////////////////////////////////
  // Command bits: only defined fields are stored, each by its own byte lane
  assign wr_cmd = cfg_wr_in && addr_hit(cfg_addr_in, `PCCR_OFF_CMD_STAT);
  assign wr_lane_lo = wr_cmd && cfg_be_in[`PCCR_LANE_CMD_LO];
  assign wr_lane_hi = wr_cmd && cfg_be_in[`PCCR_LANE_CMD_HI];
  assign wr_lane_stat = wr_cmd && cfg_be_in[`PCCR_LANE_STAT_HI];

  always @(posedge mclk_in) begin
    if (reset_in) begin
      io_space_control_ff <= `PCCR_RST_IO_SPACE;
    end else if (wr_lane_lo) begin
      io_space_control_ff <= cfg_wdata_in[`PCCR_BIT_IO_SPACE];
    end
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      mem_space_enable_ff <= `PCCR_RST_MEM_SPACE;
    end else if (wr_lane_lo) begin
      mem_space_enable_ff <= cfg_wdata_in[`PCCR_BIT_MEM_SPACE];
    end
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      bus_master_enable_ff <= `PCCR_RST_BUS_MASTER;
    end else if (wr_lane_lo) begin
      bus_master_enable_ff <= cfg_wdata_in[`PCCR_BIT_BUS_MASTER];
    end
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      parity_resp_enable_ff <= `PCCR_RST_PARITY_RESP;
    end else if (wr_lane_lo) begin
      parity_resp_enable_ff <= cfg_wdata_in[`PCCR_BIT_PARITY_RESP];
    end
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      sys_err_resp_enable_ff <= `PCCR_RST_SYS_ERR_RESP;
    end else if (wr_lane_hi) begin
      sys_err_resp_enable_ff <= cfg_wdata_in[`PCCR_BIT_SYS_ERR_RESP];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parity-seen flag: write one clears, a new error wins over the clear
  always @(posedge mclk_in) begin
    if (reset_in) begin
      parity_error_seen_flag_ff <= 1'b0;
    end else if (any_perr) begin
      parity_error_seen_flag_ff <= 1'b1;
    end else if (wr_lane_stat && cfg_wdata_in[`PCCR_BIT_PARITY_SEEN]) begin
      parity_error_seen_flag_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error responses
  always @(posedge mclk_in) begin
    if (reset_in) begin
      sys_err_n_out <= 1'b1;
      sys_err_n_oe_out <= 1'b0;
      host_sys_err_set_out <= 1'b0;
    end else begin
      // Open-drain: drive low for one cycle per address parity error
      sys_err_n_out <= 1'b0;
      sys_err_n_oe_out <= addr_perr_pulse && sys_err_resp_enable_ff;
      // Disabled response leaves errors ignored
      host_sys_err_set_out <= any_perr && parity_resp_enable_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Gated decode and mastering
  assign master_start_out = master_req_in && bus_master_enable_ff;
  assign mem_decode_out = mem_access_in && mem_space_enable_ff;
  assign io_decode_out = io_access_in && !io_space_control_ff;
  assign bus_master_enable_out = bus_master_enable_ff;
  assign mem_space_enable_out = mem_space_enable_ff;
  assign io_space_control_out = io_space_control_ff;
  assign parity_resp_enable_out = parity_resp_enable_ff;
  assign sys_err_resp_enable_out = sys_err_resp_enable_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  assign rd_cmd = cfg_rd_in && addr_hit(cfg_addr_in, `PCCR_OFF_CMD_STAT);
  assign rd_cls = cfg_rd_in && addr_hit(cfg_addr_in, `PCCR_OFF_CLASS_REV);

  // Reserved and unmodelled status bits keep the zero loaded first
  always @* begin
    cmd_stat_word = 32'h0000_0000;
    cmd_stat_word[`PCCR_BIT_PARITY_SEEN] = parity_error_seen_flag_ff;
    cmd_stat_word[`PCCR_BIT_NEW_CAPS] = option_config_reg_in[`PCCR_BIT_OPT_PM_CAP];
    cmd_stat_word[`PCCR_BIT_SYS_ERR_RESP] = sys_err_resp_enable_ff;
    cmd_stat_word[`PCCR_BIT_PARITY_RESP] = parity_resp_enable_ff;
    cmd_stat_word[`PCCR_BIT_BUS_MASTER] = bus_master_enable_ff;
    cmd_stat_word[`PCCR_BIT_MEM_SPACE] = mem_space_enable_ff;
    cmd_stat_word[`PCCR_BIT_IO_SPACE] = io_space_control_ff;
  end

  assign class_rev_word = {`PCCR_BASE_CLASS,
                           `PCCR_SUBCLASS,
                           `PCCR_RESERVED_BYTE,
                           REVISION_NUMBER,
                           STEP_NUMBER};
  always @(posedge mclk_in) begin
    if (reset_in) begin
      cfg_rdata_out <= 32'h0000_0000;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_rd_in;
      if (rd_cmd) begin
        cfg_rdata_out <= cmd_stat_word;
      end else if (rd_cls) begin
        cfg_rdata_out <= class_rev_word;
      end else begin
        cfg_rdata_out <= 32'h0000_0000;
      end
    end
  end
endmodule // pccr_cfg_regs

// [pccr_cfg_regs_assertions.sv]
`timescale 1ns/1ps
module pccr_cfg_regs_assertions (
  input wire mclk_in, input wire reset_in, input wire cfg_rd_in, input wire [7:0] cfg_addr_in,
  input wire [31:0] cfg_rdata_out, input wire [31:0] option_config_reg_in,
  input wire master_req_in, input wire mem_access_in, input wire io_access_in,
  input wire master_start_out, input wire mem_decode_out, input wire io_decode_out,
  input wire sys_err_n_out, input wire sys_err_n_oe_out, input wire host_sys_err_set_out,
  input wire bus_master_enable_out, input wire mem_space_enable_out, input wire io_space_control_out,
  input wire parity_resp_enable_out, input wire sys_err_resp_enable_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence s_cmd_rd; cfg_rd_in && cfg_addr_in == 8'h04; endsequence
  sequence s_cls_rd; cfg_rd_in && cfg_addr_in == 8'h08; endsequence
  property p_caps; s_cmd_rd |=> cfg_rdata_out[20] == $past(option_config_reg_in[19]); endproperty
  a_caps: assert property (p_caps) else $error("caps bit wrong");
  property p_serr; sys_err_n_oe_out |-> !sys_err_n_out && $past(sys_err_resp_enable_out); endproperty
  a_serr: assert property (p_serr) else $error("system error drive wrong");
  property p_ign; !parity_resp_enable_out && !$past(parity_resp_enable_out) |-> !host_sys_err_set_out; endproperty
  a_ign: assert property (p_ign) else $error("host flag while disabled");
  property p_host; host_sys_err_set_out |-> $past(parity_resp_enable_out); endproperty
  a_host: assert property (p_host) else $error("host flag without parity response");
  property p_mst; master_start_out == (master_req_in && bus_master_enable_out); endproperty
  a_mst: assert property (p_mst) else $error("master start wrong");
  property p_mem; mem_decode_out == (mem_access_in && mem_space_enable_out); endproperty
  a_mem: assert property (p_mem) else $error("memory decode wrong");
  property p_io; io_decode_out == (io_access_in && !io_space_control_out); endproperty
  a_io: assert property (p_io) else $error("io decode wrong");
  property p_bcc; s_cls_rd |=> cfg_rdata_out[31:24] == 8'h02; endproperty
  a_bcc: assert property (p_bcc) else $error("base class wrong");
  property p_sub; s_cls_rd |=> cfg_rdata_out[23:8] == 16'h0000; endproperty
  a_sub: assert property (p_sub) else $error("subclass wrong");
  property p_rsv; s_cmd_rd |=> cfg_rdata_out[19:9] == 11'h000 && !cfg_rdata_out[7] && cfg_rdata_out[5:3] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // pccr_cfg_regs_assertions
bind pccr_cfg_regs pccr_cfg_regs_assertions pccr_cfg_regs_assertions_inst (.*);

// [pccr_host_model.sv]
`timescale 1ns/1ps
module pccr_host_model (
  input wire mclk_in, input wire [31:0] cfg_rdata_in, output reg cfg_wr_out, output reg cfg_rd_out,
  output reg [7:0] cfg_addr_out, output reg [31:0] cfg_wdata_out, output reg [3:0] cfg_be_out
);
  initial begin
    {cfg_wr_out, cfg_rd_out, cfg_addr_out, cfg_wdata_out, cfg_be_out} = 46'h0;
  end
  // Released address and data lines show the inverse so stale values never look valid; byte enables keep their value
  task wr(input [7:0] a, input [31:0] d, input [3:0] be);
    begin
      @(posedge mclk_in); #1 {cfg_wr_out, cfg_addr_out, cfg_wdata_out, cfg_be_out} = {1'b1, a, d, be};
      @(posedge mclk_in); #1 {cfg_wr_out, cfg_addr_out, cfg_wdata_out} = {1'b0, ~a, ~d};
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge mclk_in); #1 {cfg_rd_out, cfg_addr_out} = {1'b1, a};
      @(posedge mclk_in); #1 {cfg_rd_out, cfg_addr_out} = {1'b0, ~a};
      d = cfg_rdata_in;
    end
  endtask
endmodule // pccr_host_model

// [test_pccr_cfg_regs.sv]
`timescale 1ns/1ps
module test_pccr_cfg_regs;
  reg mclk = 0, rst = 1, mreq = 0, macc = 0, iacc = 0, aperr = 0, dperr = 0, oe_seen, host_seen;
  wire wr, rd, mst, memd, iod, oe, hset, rvld, serrn;
  wire [4:0] ens;
  reg [31:0] opt = 32'h00080000;
  wire [7:0] addr;
  wire [31:0] wdata, rdata;
  wire [3:0] be;
  reg [31:0] v;
  integer miscompares = 0, comparisons = 0;
  always #2 mclk = ~mclk;
  pccr_host_model pccr_host_model_inst (.mclk_in(mclk), .cfg_rdata_in(rdata), .cfg_wr_out(wr), .cfg_rd_out(rd),
    .cfg_addr_out(addr), .cfg_wdata_out(wdata), .cfg_be_out(be));
  // Nonzero revision and step so the fixed fields show up; the values are arbitrary
  pccr_cfg_regs #(.REVISION_NUMBER(4'h3), .STEP_NUMBER(4'h5)) pccr_cfg_regs_inst (.mclk_in(mclk), .reset_in(rst),
    .cfg_wr_in(wr), .cfg_rd_in(rd),
    .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_be_in(be), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvld),
    .option_config_reg_in(opt), .addr_parity_err_in(aperr), .data_parity_err_in(dperr),
    .master_req_in(mreq), .mem_access_in(macc), .io_access_in(iacc), .master_start_out(mst),
    .mem_decode_out(memd), .io_decode_out(iod), .sys_err_n_out(serrn), .sys_err_n_oe_out(oe),
    .host_sys_err_set_out(hset), .bus_master_enable_out(ens[4]), .mem_space_enable_out(ens[3]),
    .io_space_control_out(ens[2]), .parity_resp_enable_out(ens[1]), .sys_err_resp_enable_out(ens[0]));
  task check(input string what, input [31:0] exp, input [31:0] got);
    begin
      comparisons++;
      if (got !== exp) begin
        miscompares++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task watch;
    begin
      {oe_seen, host_seen} = 2'b00;
      repeat (10) begin
        @(posedge mclk); #1 {oe_seen, host_seen} = {oe_seen | oe, host_seen | hset};
      end
    end
  endtask
  task test_defaults;
    begin
      pccr_host_model_inst.rd(8'h04, v); check("cmd_reset", 32'h00100107, v);
      check("rvalid", 32'h1, {31'h0, rvld});
      check("enables_reset", 32'h1d, {27'h0, ens});
      opt = 32'hfff7ffff;
      pccr_host_model_inst.rd(8'h04, v); check("caps_clear", 32'h00000107, v);
      opt = 32'h00080000;
      pccr_host_model_inst.wr(8'h08, 32'hffffffff, 4'hf);
      pccr_host_model_inst.rd(8'h08, v); check("class_rev", 32'h02000035, v);
      $display("test defaults done");
    end
  endtask
  task test_decode;
    begin
      pccr_host_model_inst.wr(8'h04, 32'hffffffff, 4'hf);
      pccr_host_model_inst.rd(8'h04, v); check("cmd_ones", 32'h00100147, v);
      check("enables_ones", 32'h1f, {27'h0, ens});
      {mreq, macc, iacc} = 3'b111;
      #1 check("decode_on", 32'h6, {29'h0, mst, memd, iod});
      pccr_host_model_inst.wr(8'h04, 32'h00000000, 4'hf);
      #1 check("decode_off", 32'h1, {29'h0, mst, memd, iod});
      check("enables_zero", 32'h0, {27'h0, ens});
      {mreq, macc, iacc} = 3'b000;
      $display("test decode done");
    end
  endtask
  task test_parity;
    begin
      pccr_host_model_inst.wr(8'h04, 32'h00000140, 4'hf);
      aperr = 1; watch; aperr = 0;
      check("addr_err_pulses", 32'h3, {30'h0, oe_seen, host_seen});
      check("serr_level", 32'h0, {31'h0, serrn});
      pccr_host_model_inst.rd(8'h04, v); check("flag_set", 32'h1, v[31]);
      pccr_host_model_inst.wr(8'h04, 32'h80000000, 4'h8);
      pccr_host_model_inst.rd(8'h04, v); check("flag_clear", 32'h00100140, v);
      pccr_host_model_inst.wr(8'h04, 32'h00000040, 4'hf);
      aperr = 1; watch; aperr = 0;
      check("serr_disabled", 32'h1, {30'h0, oe_seen, host_seen});
      pccr_host_model_inst.wr(8'h04, 32'h80000100, 4'hf);
      dperr = 1; watch; dperr = 0;
      check("ignored_pulses", 32'h0, {30'h0, oe_seen, host_seen});
      pccr_host_model_inst.rd(8'h04, v); check("flag_disabled", 32'h1, v[31]);
      $display("test parity done");
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // The tests need under 200 cycles; 1000 cycles means a hang
  initial begin
    #4000 miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst = 0;
    test_defaults;
    test_decode;
    test_parity;
    report_and_stop;
  end
endmodule // test_pccr_cfg_regs
